// File: core/flow_ctrl_pkg.sv
// constants for the pause and priority flow control configuration block
// assumes a 32-bit apb register bus and client logic on the same clock
package flow_ctrl_pkg;
  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [7:0]  FLOW_CFG_OFFSET    = 8'h00;
  localparam logic [7:0]  FLOW_STATUS_OFFSET = 8'h04;
  localparam int          ADDR_WIDTH         = 8;
  // ******************************************************************
  // configuration fields
  // ******************************************************************
  localparam int          TX_PAUSE_EN_BIT    = 30;
  localparam int          RX_PAUSE_EN_BIT    = 29;
  localparam int          TX_PFC_EN_BIT      = 26;
  localparam int          RX_PFC_EN_BIT      = 25;
  localparam int          AUTO_XON_BIT       = 20;
  localparam int          TX_PRIO_LSB        = 8;
  localparam int          RX_PRIO_LSB        = 0;
  localparam int          PRIO_COUNT         = 8;
  // ******************************************************************
  // reset values and writable masks
  // ******************************************************************
  localparam logic [31:0] CFG_RESET_BASE     = 32'h6000_0000;
  localparam logic [31:0] CFG_RESET_PFC      = 32'h0010_ffff;
  localparam logic [31:0] CFG_MASK_BASE      = 32'h6000_0000;
  localparam logic [31:0] CFG_MASK_PFC       = 32'h0610_ffff;
  // ******************************************************************
  // status fields
  // ******************************************************************
  localparam int          STAT_INHIBIT_BIT   = 0;
  localparam int          STAT_PFC_LSB       = 8;
  localparam int          STAT_COUNT_LSB     = 16;
  localparam int          QUANTA_WIDTH       = 16;
  // ******************************************************************
  // transmit request sequencer states
  // ******************************************************************
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_PAUSE = 3'b010,
    TX_PFC   = 3'b100
  } tx_state_e;
endpackage : flow_ctrl_pkg

// File: core/request_edge_tracker.sv
// tracks rising and falling edges of client pause requests
// assumes requests come from logic on clock_i; pending bits cleared by taker
`timescale 1ns/1ps
module request_edge_tracker #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock_i,    // system clock
  input  wire logic             resetn_i,   // async reset, active low
  input  wire logic [WIDTH-1:0] request_i,  // client request levels
  input  wire logic [WIDTH-1:0] enable_i,   // per-request enables
  input  wire logic             xon_on_i,   // send xon on request drop
  input  wire logic             take_i,     // pending bits taken this cycle
  output logic      [WIDTH-1:0] xoff_pend_o,// pause frame owed
  output logic      [WIDTH-1:0] xon_pend_o  // xon frame owed
);
  // ******************************************************************
  // edge detection
  // ******************************************************************
  logic [WIDTH-1:0] request_last;
  wire  [WIDTH-1:0] rise_event = request_i & ~request_last & enable_i;
  wire  [WIDTH-1:0] fall_event = ~request_i & request_last & enable_i;
  wire  [WIDTH-1:0] keep_mask  = take_i ? '0 : '1;
  // newest edge wins; a fresh edge survives a take in the same cycle
  wire  [WIDTH-1:0] next_xoff  = rise_event | (xoff_pend_o & keep_mask & ~fall_event);
  wire  [WIDTH-1:0] next_xon   = (fall_event & {WIDTH{xon_on_i}})
                                 | (xon_pend_o & keep_mask & ~rise_event);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      request_last <= '0;
      xoff_pend_o  <= '0;
      xon_pend_o   <= '0;
    end else begin
      request_last <= request_i;
      xoff_pend_o  <= next_xoff;
      xon_pend_o   <= next_xon;
    end
  end

  pend_on_rise_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rise_event[0] |=> xoff_pend_o[0] && !xon_pend_o[0])
    else $error("rising request did not raise pending pause");
endmodule : request_edge_tracker

// File: core/pause_flow_control_config.sv
// flow control configuration register and pause request sequencing
// assumes apb master, client and mac datapath all on clock_i
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pause_flow_control_config
  import flow_ctrl_pkg::*;
#(
  parameter bit PFC_SUPPORT = 1'b1
) (
  input  wire logic                    clock_i,                     // 20 mhz clock
  input  wire logic                    resetn_i,                    // async reset, active low
  input  wire logic                    psel,                        // apb select
  input  wire logic                    penable,                     // apb enable
  input  wire logic                    pwrite,                      // apb direction
  input  wire logic [ADDR_WIDTH-1:0]   paddr,                       // apb byte address
  input  wire logic [31:0]             pwdata,                      // apb write data
  output logic      [31:0]             prdata,                      // apb read data
  output logic                         pready,                      // apb ready
  output logic                         pslverr,                     // apb error
  input  wire logic                    pause_request_i,             // client pause request
  input  wire logic                    tx_priority0_request_valid_i,// priority 0 request
  input  wire logic                    tx_priority1_request_valid_i,// priority 1 request
  input  wire logic                    tx_priority2_request_valid_i,// priority 2 request
  input  wire logic                    tx_priority3_request_valid_i,// priority 3 request
  input  wire logic                    tx_priority4_request_valid_i,// priority 4 request
  input  wire logic                    tx_priority5_request_valid_i,// priority 5 request
  input  wire logic                    tx_priority6_request_valid_i,// priority 6 request
  input  wire logic                    tx_priority7_request_valid_i,// priority 7 request
  input  wire logic                    tx_frame_ack_i,              // transmitter took frame
  input  wire logic                    rx_pause_frame_i,            // pause frame received pulse
  input  wire logic [QUANTA_WIDTH-1:0] rx_pause_quanta_i,           // its quanta
  input  wire logic                    rx_pfc_frame_i,              // priority frame received pulse
  input  wire logic [PRIO_COUNT-1:0]   rx_pfc_class_valid_i,        // priorities valid in it
  output logic                         tx_pause_send_o,             // send pause frame
  output logic                         tx_pause_xon_o,              // pause frame has zero quanta
  output logic                         tx_pfc_send_o,               // send priority frame
  output logic      [PRIO_COUNT-1:0]   tx_pfc_xoff_o,               // priorities paused
  output logic      [PRIO_COUNT-1:0]   tx_pfc_xon_o,                // priorities released
  output logic                         tx_inhibit_o,                // transmitter held off
  output logic                         rx_pause_forward_o,          // pass pause frame to client
  output logic                         rx_pfc_forward_o,            // pass priority frame to client
  output logic      [PRIO_COUNT-1:0]   rx_priority_valid_o          // received priority pulses
);
  // ******************************************************************
  // configuration register
  // ******************************************************************
  localparam logic [31:0] CFG_RESET = CFG_RESET_BASE | (PFC_SUPPORT ? CFG_RESET_PFC : 32'h0000_0000);
  localparam logic [31:0] CFG_MASK  = CFG_MASK_BASE | (PFC_SUPPORT ? CFG_MASK_PFC : 32'h0000_0000);

  logic [31:0]             flow_control_configuration;
  logic [QUANTA_WIDTH-1:0] pause_count;
  tx_state_e               tx_state;
  tx_state_e               next_tx_state;

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction : hit

  wire setup_phase = psel && !penable;
  wire access_done = psel && penable && pready;
  wire cfg_hit     = hit(paddr, FLOW_CFG_OFFSET);
  wire status_hit  = hit(paddr, FLOW_STATUS_OFFSET);
  wire cfg_write   = access_done && pwrite && cfg_hit;
  // reserved and absent fields never take a write
  wire [31:0] next_cfg = (pwdata & CFG_MASK) | (flow_control_configuration & ~CFG_MASK);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flow_control_configuration <= CFG_RESET;
    end else if (cfg_write) begin
      flow_control_configuration <= next_cfg;
    end
  end

  wire                  tx_pause_en = flow_control_configuration[TX_PAUSE_EN_BIT];
  wire                  rx_pause_en = flow_control_configuration[RX_PAUSE_EN_BIT];
  wire                  tx_pfc_en   = flow_control_configuration[TX_PFC_EN_BIT];
  wire                  rx_pfc_en   = flow_control_configuration[RX_PFC_EN_BIT];
  wire                  auto_xon    = flow_control_configuration[AUTO_XON_BIT];
  wire [PRIO_COUNT-1:0] tx_prio_en  = flow_control_configuration[TX_PRIO_LSB +: PRIO_COUNT];
  wire [PRIO_COUNT-1:0] rx_prio_en  = flow_control_configuration[RX_PRIO_LSB +: PRIO_COUNT];

  // ******************************************************************
  // apb read path
  // ******************************************************************
  logic [PRIO_COUNT-1:0] pfc_xoff_pend;
  logic [PRIO_COUNT-1:0] pfc_xon_pend;
  logic                  pause_xoff_pend;
  logic                  pause_xon_pend;

  wire [31:0] status_word = {pause_count, pfc_xoff_pend | pfc_xon_pend, 7'h00, tx_inhibit_o};
  wire [31:0] read_word   = cfg_hit ? flow_control_configuration : (status_hit ? status_word : 32'h0000_0000);
  wire        bad_address = !cfg_hit && !status_hit;

  // answer is registered at the setup edge, so access phase always has one cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      prdata  <= (setup_phase && !pwrite) ? read_word : 32'h0000_0000;
      pslverr <= setup_phase && bad_address;
    end
  end

  // ******************************************************************
  // transmit request tracking
  // ******************************************************************
  wire [PRIO_COUNT-1:0] prio_request = {tx_priority7_request_valid_i, tx_priority6_request_valid_i,
                                        tx_priority5_request_valid_i, tx_priority4_request_valid_i,
                                        tx_priority3_request_valid_i, tx_priority2_request_valid_i,
                                        tx_priority1_request_valid_i, tx_priority0_request_valid_i};
  // with priority control off every priority request is masked
  wire [PRIO_COUNT-1:0] prio_active  = tx_prio_en & {PRIO_COUNT{tx_pfc_en}};
  wire                  pfc_pending  = |(pfc_xoff_pend | pfc_xon_pend);
  wire                  pause_pending = pause_xoff_pend || pause_xon_pend;
  wire                  take_pause   = (tx_state == TX_IDLE) && pause_pending;
  wire                  take_pfc     = (tx_state == TX_IDLE) && !pause_pending && pfc_pending;

  request_edge_tracker #(
    .WIDTH       (PRIO_COUNT)
  ) pfc_tracker (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .request_i   (prio_request),
    .enable_i    (prio_active),
    .xon_on_i    (auto_xon),
    .take_i      (take_pfc),
    .xoff_pend_o (pfc_xoff_pend),
    .xon_pend_o  (pfc_xon_pend)
  );

  request_edge_tracker #(
    .WIDTH       (1)
  ) pause_tracker (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .request_i   (pause_request_i),
    .enable_i    (tx_pause_en),
    .xon_on_i    (auto_xon),
    .take_i      (take_pause),
    .xoff_pend_o (pause_xoff_pend),
    .xon_pend_o  (pause_xon_pend)
  );

  // ******************************************************************
  // transmit frame sequencer
  // ******************************************************************
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: begin
        if (take_pause) begin
          next_tx_state = TX_PAUSE;
        end else if (take_pfc) begin
          next_tx_state = TX_PFC;
        end
      end
      TX_PAUSE, TX_PFC: begin
        if (tx_frame_ack_i) begin
          next_tx_state = TX_IDLE;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_state        <= TX_IDLE;
      tx_pause_send_o <= 1'b0;
      tx_pause_xon_o  <= 1'b0;
      tx_pfc_send_o   <= 1'b0;
      tx_pfc_xoff_o   <= '0;
      tx_pfc_xon_o    <= '0;
    end else begin
      tx_state        <= next_tx_state;
      tx_pause_send_o <= (next_tx_state == TX_PAUSE);
      tx_pfc_send_o   <= (next_tx_state == TX_PFC);
      if (take_pause) begin
        tx_pause_xon_o <= pause_xon_pend;
      end
      if (take_pfc) begin
        tx_pfc_xoff_o <= pfc_xoff_pend;
        tx_pfc_xon_o  <= pfc_xon_pend;
      end
    end
  end

  // ******************************************************************
  // receive side
  // ******************************************************************
  wire                    act_pause  = rx_pause_frame_i && rx_pause_en;
  wire [QUANTA_WIDTH-1:0] count_dec  = (pause_count != '0) ? pause_count - QUANTA_WIDTH'(1) : pause_count;
  wire [QUANTA_WIDTH-1:0] next_count = act_pause ? rx_pause_quanta_i : count_dec;

  // one quantum is counted per clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pause_count         <= '0;
      tx_inhibit_o        <= 1'b0;
      rx_pause_forward_o  <= 1'b0;
      rx_pfc_forward_o    <= 1'b0;
      rx_priority_valid_o <= '0;
    end else begin
      pause_count         <= next_count;
      tx_inhibit_o        <= (next_count != '0);
      rx_pause_forward_o  <= rx_pause_frame_i && !rx_pause_en;
      rx_pfc_forward_o    <= rx_pfc_frame_i && !rx_pfc_en;
      rx_priority_valid_o <= (rx_pfc_frame_i && rx_pfc_en) ? (rx_pfc_class_valid_i & rx_prio_en) : '0;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  pause_inhibit_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    act_pause && rx_pause_quanta_i > 16'h0002 |=> tx_inhibit_o [*2])
    else $error("received pause did not inhibit transmitter");

  pause_forward_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rx_pause_frame_i |=> rx_pause_forward_o == !$past(rx_pause_en))
    else $error("pause frame forwarding wrong");

  pfc_send_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(prio_request[7]) && prio_active[7] && tx_state == TX_IDLE && !pause_pending && !pfc_pending
    |-> ##2 tx_pfc_send_o && tx_pfc_xoff_o[7])
    else $error("priority request did not send a frame");

  pfc_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !tx_pfc_en && !pfc_pending && tx_state == TX_IDLE && !pause_pending |=> !tx_pfc_send_o)
    else $error("priority frame sent while disabled");

  rx_pfc_valid_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rx_pfc_frame_i && rx_pfc_en |=> rx_priority_valid_o == $past(rx_pfc_class_valid_i & rx_prio_en))
    else $error("receive priority outputs wrong");

  rx_pfc_pass_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rx_pfc_frame_i && !rx_pfc_en |=> rx_pfc_forward_o && rx_priority_valid_o == '0)
    else $error("disabled priority frame acted on");

  auto_xon_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $fell(pause_request_i) && tx_pause_en && auto_xon && tx_state == TX_IDLE && !pause_pending && !pfc_pending
    |-> ##2 tx_pause_send_o && tx_pause_xon_o)
    else $error("dropped pause request sent no xon");

  pause_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !tx_pause_en && !pause_pending && tx_state != TX_PAUSE |=> !tx_pause_send_o)
    else $error("pause frame sent while disabled");

  reserved_zero_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (flow_control_configuration & ~CFG_MASK) == 32'h0000_0000)
    else $error("reserved configuration bits set");

  apb_ready_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    setup_phase |=> pready)
    else $error("apb access not answered");
endmodule : pause_flow_control_config

// File: dv/tx_ack_model.sv
// transmitter side model: acknowledges frame requests after a chosen delay
// assumes the block's send outputs are levels held until acknowledged
`timescale 1ns/1ps
module tx_ack_model (
  input  wire logic       clock_i,  // system clock
  input  wire logic       resetn_i, // async reset, active low
  input  wire logic       send_i,   // frame request from the block
  input  wire logic [3:0] delay_i,  // cycles to hold off the ack
  output logic            ack_o     // transmitter took the frame
);
  logic [3:0] wait_cnt;
  logic       busy;

  // slow or prompt transmitter, one-cycle ack pulse
  assign busy = send_i && !ack_o;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_cnt <= 4'h0;
      ack_o    <= 1'b0;
    end else begin
      ack_o    <= busy && wait_cnt == delay_i;
      wait_cnt <= (busy && wait_cnt != delay_i) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : tx_ack_model

// File: dv/tb_top.sv
// self-checking bench for the flow control configuration block
// assumes apb master, client requests and receive pulses all on clock_i
`timescale 1ns/1ps
module tb_top;
  import flow_ctrl_pkg::*;
  logic        clock_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pause_request_i = 0, rx_pf = 0, rx_cf = 0, ack, err, pready, pslverr;
  logic        ps, px, cs, inh, fp, fc, ps_d = 0, cs_d = 0;
  logic [7:0]  paddr = 0, req = 0, rx_cls = 0, cx, cn, rv, r;
  logic [15:0] quanta = 0;
  logic [31:0] pwdata = 0, prdata, rd, q_exp[$], q_seen[$];
  logic [3:0]  dly = 0;
  int          n_errors = 0, cmp_count = 0, len = 0, p;

  always #25 clock_i = ~clock_i;

  pause_flow_control_config #(.PFC_SUPPORT(1'b1)) u_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pause_request_i(pause_request_i), .tx_priority0_request_valid_i(req[0]),
    .tx_priority1_request_valid_i(req[1]), .tx_priority2_request_valid_i(req[2]),
    .tx_priority3_request_valid_i(req[3]), .tx_priority4_request_valid_i(req[4]),
    .tx_priority5_request_valid_i(req[5]), .tx_priority6_request_valid_i(req[6]),
    .tx_priority7_request_valid_i(req[7]), .tx_frame_ack_i(ack), .rx_pause_frame_i(rx_pf),
    .rx_pause_quanta_i(quanta), .rx_pfc_frame_i(rx_cf), .rx_pfc_class_valid_i(rx_cls),
    .tx_pause_send_o(ps), .tx_pause_xon_o(px), .tx_pfc_send_o(cs), .tx_pfc_xoff_o(cx),
    .tx_pfc_xon_o(cn), .tx_inhibit_o(inh), .rx_pause_forward_o(fp), .rx_pfc_forward_o(fc),
    .rx_priority_valid_o(rv));

  tx_ack_model u_tx (.clock_i(clock_i), .resetn_i(resetn_i), .send_i(ps | cs), .delay_i(dly), .ack_o(ack));

  // ******************************************************************
  // monitor: every frame and receive event becomes one queue entry
  // ******************************************************************
  always @(negedge clock_i) begin
    if (ps & !ps_d) q_seen.push_back({8'h01, 23'h0, px});
    if (cs & !cs_d) q_seen.push_back({16'h0200, cx, cn});
    if (inh) len++;
    else if (len > 0) begin
      q_seen.push_back(32'h0300_0000 | len);
      len = 0;
    end
    if (fp) q_seen.push_back(32'h0400_0000);
    if (fc) q_seen.push_back(32'h0500_0000);
    if (|rv) q_seen.push_back({24'h060000, rv});
    ps_d = ps;
    cs_d = cs;
  end

  // ******************************************************************
  // tasks
  // ******************************************************************
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    k = 0;
    // no local limit: the watchdog ends a hang
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1);
    chk("apb wait", 32'h1, k);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task cfg(input logic [31:0] v);
    apb(1'b1, 8'h00, v);
    dly <= 4'($urandom_range(7));
  endtask : cfg

  task drive(input logic pr, input logic [7:0] rq, input logic pf, input logic cf);
    @(posedge clock_i);
    pause_request_i <= pr;
    req             <= rq;
    rx_pf           <= pf;
    rx_cf           <= cf;
    @(posedge clock_i);
    rx_pf <= 1'b0;
    rx_cf <= 1'b0;
  endtask : drive

  task flush;
    repeat (20) @(posedge clock_i);
    chk("event count", q_exp.size(), q_seen.size());
    while (q_exp.size() > 0 && q_seen.size() > 0) chk("event", q_exp.pop_front(), q_seen.pop_front());
    q_exp.delete();
    q_seen.delete();
  endtask : flush

  task summarize;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial begin
    #(50 * 8000);
    n_errors++;
    summarize();
  end

  // ******************************************************************
  // scenarios
  // ******************************************************************
  initial begin
    void'($urandom(32'h877f));
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("cfg reset", 32'h6010ffff, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("status idle", 32'h0, rd);
    apb(1'b1, 8'h00, 32'hffffffff);
    apb(1'b0, 8'h00, 32'h0);
    chk("cfg mask", 32'h6610ffff, rd);
    apb(1'b1, 8'h08, 32'h0);
    chk("unmapped err", 32'h1, err);
    for (int en = 1; en >= 0; en--) begin
      cfg({1'b0, en[0], 30'h0010ffff});
      drive(1'b1, 8'h0, 1'b0, 1'b0);
      if (en) q_exp.push_back(32'h0100_0000);
      flush();
      drive(1'b0, 8'h0, 1'b0, 1'b0);
      if (en) q_exp.push_back(32'h0100_0001);
      flush();
    end
    cfg(32'h0410ffff);
    for (p = 0; p < 8; p++) begin
      drive(1'b0, 8'h1 << p, 1'b0, 1'b0);
      q_exp.push_back({16'h0200, 8'h1 << p, 8'h0});
      flush();
      drive(1'b0, 8'h0, 1'b0, 1'b0);
      q_exp.push_back({16'h0200, 8'h0, 8'h1 << p});
      flush();
    end
    p = $urandom_range(7);
    r = 8'($urandom()) | (8'h1 << p);
    cfg(32'h0410ffff & ~(32'h100 << p));
    drive(1'b0, r, 1'b0, 1'b0);
    if ((r & ~(8'h1 << p)) != 0) q_exp.push_back({16'h0200, r & ~(8'h1 << p), 8'h0});
    flush();
    drive(1'b0, 8'h0, 1'b0, 1'b0);
    if ((r & ~(8'h1 << p)) != 0) q_exp.push_back({16'h0200, 8'h0, r & ~(8'h1 << p)});
    flush();
    cfg(32'h0010ffff);
    drive(1'b0, r, 1'b0, 1'b0);
    drive(1'b0, 8'h0, 1'b0, 1'b0);
    flush();
    cfg(32'h0400ffff);
    drive(1'b0, 8'h80, 1'b0, 1'b0);
    q_exp.push_back(32'h0200_8000);
    drive(1'b0, 8'h0, 1'b0, 1'b0);
    flush();
    for (int en = 1; en >= 0; en--) begin
      cfg({2'b00, en[0], 29'h0});
      quanta <= 16'($urandom_range(1, 8));
      drive(1'b0, 8'h0, 1'b1, 1'b0);
      q_exp.push_back(en ? (32'h0300_0000 | quanta) : 32'h0400_0000);
      flush();
    end
    r = 8'($urandom()) | 8'h01;
    rx_cls <= 8'($urandom()) | 8'h01;
    cfg({24'h020000, r});
    drive(1'b0, 8'h0, 1'b0, 1'b1);
    q_exp.push_back({24'h060000, rx_cls & r});
    flush();
    cfg(32'h0000_00ff);
    drive(1'b0, 8'h0, 1'b0, 1'b1);
    q_exp.push_back(32'h0500_0000);
    flush();
    summarize();
  end
endmodule : tb_top
